// *** src/digipot_serial_latch_loader.sv ***
// serial front end of a multi-channel 256-step digital potentiometer
`timescale 1ns/1ps
module digipot_serial_latch_loader
#(
    parameter bit SIX_CHANNEL = 1'b0 // 0: four-channel, 1: six-channel
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic serial_in,
    input wire logic chipSel_n,
    input wire logic preset_midscale_n,
    input wire logic terminal_a_open_n,
    output logic serialOutOe,
    output logic serialOut,
    output logic [5:0] channelOpen,
    output logic [47:0] wiper_latch
);
    import digipot_pkg::*;

    // every pin synchroniser and the shift state live in one struct
    typedef struct packed
    {
        logic [1:0] clkSync; // serial clock synchroniser
        logic [1:0] dataSync; // serial data synchroniser
        logic [1:0] csSync; // chip select synchroniser
        logic [1:0] presetSync; // preset synchroniser
        logic [1:0] shdnSync; // shutdown synchroniser
        logic clkPrev; // last synced serial clock
        logic csPrev; // last synced chip select
        logic [WORD_W-1:0] shiftReg; // serial input register
        logic sdoLow; // open-drain pull-down
        logic [5:0] open; // shutdown state per channel
    } state_t;

    state_t cur; // registered state
    state_t next_cur; // next state
    logic clkRise; // serial clock rising edge
    logic csRise; // chip select rising edge
    logic presetNow; // preset asserted
    logic loadEn; // latch write strobe
    logic addrValid; // decoded address hits a latch
    logic [ADDR_W-1:0] wordAddr; // address field
    logic [VALUE_W-1:0] wordValue; // data field

    // edge detect reads only the second synchroniser flop
    assign clkRise = cur.clkSync[1] && !cur.clkPrev;
    assign csRise = cur.csSync[1] && !cur.csPrev;
    // fields of the eleven-bit word, address on top
    assign wordAddr = cur.shiftReg[WORD_W-1 -: ADDR_W];
    assign wordValue = cur.shiftReg[VALUE_W-1:0];
    // preset pin exists only on the four-channel part
    assign presetNow = !SIX_CHANNEL && !cur.presetSync[1];

    // address decode by variant
    always_comb
    begin
        if (wordAddr < 3'(CHAN_QUAD))
            addrValid = 1'b1;
        else if (SIX_CHANNEL && wordAddr == ADDR_CH5)
            addrValid = 1'b1;
        else if (SIX_CHANNEL && wordAddr == ADDR_CH6)
            addrValid = 1'b1;
        else
            addrValid = 1'b0;
    end

    // select rise with a decoded address writes exactly one latch unless preset is active
    assign loadEn = csRise && addrValid;

    // next-state logic: synchronise, shift, serial out, shutdown
    always_comb
    begin
        next_cur = cur;
        next_cur.clkSync = {cur.clkSync[0], serialClk};
        next_cur.dataSync = {cur.dataSync[0], serial_in};
        next_cur.csSync = {cur.csSync[0], chipSel_n};
        next_cur.presetSync = {cur.presetSync[0], preset_midscale_n};
        next_cur.shdnSync = {cur.shdnSync[0], terminal_a_open_n};
        next_cur.clkPrev = cur.clkSync[1];
        next_cur.csPrev = cur.csSync[1];
        // shift only while selected, msb enters first
        if (clkRise && !cur.csSync[1])
        begin
            next_cur.shiftReg = {cur.shiftReg[WORD_W-2:0],
                                 cur.dataSync[1]};
        end
        // pull low when the far end bit is zero
        next_cur.sdoLow = !SIX_CHANNEL && !cur.shiftReg[WORD_W-1];
        // shutdown opens terminal A; latches are untouched
        if (!SIX_CHANNEL && !cur.shdnSync[1])
            next_cur.open = OPEN_QUAD;
        else
            next_cur.open = OPEN_NONE;
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cur.clkSync <= 2'h0;
            cur.dataSync <= 2'h0;
            cur.csSync <= 2'h3;
            cur.presetSync <= 2'h3;
            cur.shdnSync <= 2'h3;
            cur.clkPrev <= 1'b0;
            cur.csPrev <= 1'b1;
            cur.shiftReg <= SHIFT_RESET;
            cur.sdoLow <= 1'b0;
            cur.open <= OPEN_NONE;
        end
        else
            cur <= next_cur;
    end

    // latch bank keeps the six codes in flops
    wiper_latch_bank wiper_latch_bank_inst
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .presetNow(presetNow),
        .writeEn(loadEn),
        .writeSel(wordAddr),
        .writeValue(wordValue),
        .latchBus(wiper_latch)
    );

    // pin-side outputs, all from flops or constants
    assign serialOut = 1'b0; // open drain: only ever drives low
    assign serialOutOe = cur.sdoLow;
    assign channelOpen = cur.open;

    // load on chip select rise lands in the addressed latch
    latch_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        loadEn && !presetNow |=>
        wiper_latch[$past(wordAddr)*8 +: 8] == $past(wordValue))
        else $error("latch not loaded on select rise");

    // preset holds every latch at midscale
    preset_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        presetNow |=> wiper_latch == {6{8'h80}})
        else $error("preset did not force midscale");

    // shutdown opens exactly the four channels
    terminal_a_open_n_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !SIX_CHANNEL && !cur.shdnSync[1] |=> channelOpen == 6'h0f)
        else $error("shutdown did not open channels");

    // shift moves data in msb first
    shift_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkRise && !cur.csSync[1] |=>
        cur.shiftReg == {$past(cur.shiftReg[9:0]), $past(cur.dataSync[1])})
        else $error("shift order wrong");

    // serial output never drives high
    sdo_drain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        serialOutOe |-> !serialOut)
        else $error("serial output drove high");

    // unused codes change no latch
    bad_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        csRise && wordAddr >= 3'h6 && !presetNow |=> $stable(wiper_latch))
        else $error("invalid address altered a latch");

    // shutdown keeps latch values
    terminal_a_open_n_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cur.shdnSync[1] && !csRise && !presetNow |=> $stable(wiper_latch))
        else $error("shutdown altered a latch");

    // six-channel part ignores preset and shutdown pins
    six_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        SIX_CHANNEL |-> !presetNow && channelOpen == 6'h00 && !serialOutOe)
        else $error("six-channel variant used absent pin");

    // after reset every latch reads midscale
    por_mid_a: assert property (@(posedge sys_clk)
        !rst_n |=> wiper_latch == {6{8'h80}})
        else $error("reset did not preset midscale");

    // pull-down follows the register's far-end bit one cycle late
    sdo_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !SIX_CHANNEL |=>
        serialOutOe == !$past(cur.shiftReg[WORD_W-1]) && !serialOut)
        else $error("serial output does not follow shift msb");

    // four-channel part refuses codes 100 to 111
    quad_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !SIX_CHANNEL && csRise && wordAddr >= 3'h4 && !presetNow |=>
        $stable(wiper_latch))
        else $error("refused address altered a latch");

    // shutdown released: every terminal connected again
    terminal_a_open_n_close_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.shdnSync[1] |=> channelOpen == OPEN_NONE)
        else $error("terminal left open without shutdown");

    // code 100 lands in the fifth latch of the six-channel part
    ch5_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        SIX_CHANNEL && csRise && wordAddr == ADDR_CH5 |=>
        wiper_latch[39:32] == $past(wordValue))
        else $error("fifth latch not loaded");

    // code 101 lands in the sixth latch of the six-channel part
    ch6_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        SIX_CHANNEL && csRise && wordAddr == ADDR_CH6 |=>
        wiper_latch[47:40] == $past(wordValue))
        else $error("sixth latch not loaded");
endmodule

// *** src/digipot_pkg.sv ***
// shared constants and types for the digital potentiometer serial loader
package digipot_pkg;
    localparam int ADDR_W = 3; // address field width
    localparam int VALUE_W = 8; // data field width
    localparam int WORD_W = ADDR_W + VALUE_W; // eleven-bit programming word
    localparam int CHAN_MAX = 6; // latches on the six-channel variant
    localparam int CHAN_QUAD = 4; // latches on the four-channel variant
    localparam logic [VALUE_W-1:0] MIDSCALE = 8'h80; // preset code
    localparam logic [WORD_W-1:0] SHIFT_RESET = 11'h000; // shift reg reset
    localparam logic [ADDR_W-1:0] ADDR_CH5 = 3'h4; // fifth latch address
    localparam logic [ADDR_W-1:0] ADDR_CH6 = 3'h5; // sixth latch address
    localparam logic [CHAN_MAX-1:0] OPEN_QUAD = 6'h0f; // shutdown, ch 1-4
    localparam logic [CHAN_MAX-1:0] OPEN_NONE = 6'h00; // all terminals on
    typedef logic [VALUE_W-1:0] value_t; // one wiper code
endpackage

// *** src/wiper_latch_bank.sv ***
// bank of wiper latches with registered read-out
`timescale 1ns/1ps
module wiper_latch_bank
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic presetNow,
    input wire logic writeEn,
    input wire logic [2:0] writeSel,
    input wire logic [7:0] writeValue,
    output logic [47:0] latchBus
);
    import digipot_pkg::*;

    typedef struct packed
    {
        logic [CHAN_MAX-1:0][VALUE_W-1:0] wiper; // latch contents
    } bank_t;

    bank_t cur; // registered state
    bank_t next_cur; // next state

    // write one latch, or preset all to midscale
    always_comb
    begin
        next_cur = cur;
        for (int i = 0; i < CHAN_MAX; i++)
        begin
            if (presetNow)
                next_cur.wiper[i] = MIDSCALE;
            else if (writeEn && writeSel == 3'(i))
                next_cur.wiper[i] = writeValue;
        end
    end

    // register; reset gives the power-on midscale preset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cur <= {CHAN_MAX{MIDSCALE}};
        else
            cur <= next_cur;
    end

    assign latchBus = cur.wiper;
endmodule

// *** verif/serial_host_model.sv ***
// host model driving the three-wire serial port of the loader
`timescale 1ns/1ps
module serial_host_model
(
    input wire logic sys_clk,
    output logic serialClk,
    output logic serial_in,
    output logic chipSel_n
);
    // clock idles low between words, select idles high
    initial
    begin
        serialClk = 1'b0;
        serial_in = 1'b1;
        chipSel_n = 1'b1;
    end
    // one word, address then value, 80 ns per clock phase
    task automatic send(input logic [10:0] word);
        chipSel_n <= 1'b0;
        for (int i = 10; i >= 0; i--)
        begin
            serial_in <= word[i];
            repeat (4) @(negedge sys_clk);
            serialClk <= 1'b1;
            repeat (4) @(negedge sys_clk);
            serialClk <= 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        chipSel_n <= 1'b1;
        serial_in <= ~word[0];
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

// *** verif/digipot_serial_latch_loader_tb_top.sv ***
// self-checking bench for the digital potentiometer serial loader
`timescale 1ns/1ps
module digipot_serial_latch_loader_tb_top;
    import digipot_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic presetN = 1'b1; // preset pin, active low
    logic shutN = 1'b1; // shutdown pin, active low
    wire serialClk, serialIn, chipSelN;
    logic oe4, out4, oe6, out6;
    logic [5:0] open4, open6;
    logic [47:0] bus4, bus6;
    logic [47:0] e4 = {6{MIDSCALE}}; // expected quad latches
    logic [47:0] e6 = {6{MIDSCALE}}; // expected six latches
    wire sdoPin = oe4 ? out4 : 1'b1; // pull-up on open drain
    int mismatches = 0;
    int num_checks = 0;
    always #10 sys_clk = ~sys_clk;
    serial_host_model serial_host_model_inst (.sys_clk(sys_clk),
        .serialClk(serialClk), .serial_in(serialIn), .chipSel_n(chipSelN));
    digipot_serial_latch_loader #(.SIX_CHANNEL(1'b0))
        digipot_serial_latch_loader_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .serialClk(serialClk), .serial_in(serialIn), .chipSel_n(chipSelN),
        .preset_midscale_n(presetN), .terminal_a_open_n(shutN),
        .serialOutOe(oe4), .serialOut(out4), .channelOpen(open4),
        .wiper_latch(bus4));
    digipot_serial_latch_loader #(.SIX_CHANNEL(1'b1))
        digipot_serial_latch_loader_inst6 (.sys_clk(sys_clk), .rst_n(rst_n),
        .serialClk(serialClk), .serial_in(serialIn), .chipSel_n(chipSelN),
        .preset_midscale_n(presetN), .terminal_a_open_n(shutN),
        .serialOutOe(oe6), .serialOut(out6), .channelOpen(open6),
        .wiper_latch(bus6));
    // compare one value, report and count
    task automatic chk(input string what, input logic [47:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // send a word and update both expectations
    task automatic put(input logic [2:0] a, input value_t v);
        serial_host_model_inst.send({a, v});
        if (a < 3'h4) e4[8*a+:8] = v;
        if (a < 3'h6) e6[8*a+:8] = v;
        if (presetN === 1'b0) e4 = {6{MIDSCALE}};
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic t_codes();
        for (int a = 0; a < 8; a++)
        begin
            put(a[2:0], 8'h5c ^ {a[2:0], 5'h03});
            chk("quad latches", bus4, e4);
            chk("six latches", bus6, e6);
        end
        put(3'h1, 8'hff);
        put(3'h2, 8'h00);
        chk("edge codes", bus4, e4);
    endtask
    task automatic t_preset();
        presetN <= 1'b0;
        repeat (8) @(negedge sys_clk);
        put(3'h0, 8'h12);
        chk("preset quad", bus4, e4);
        chk("preset six", bus6, e6);
        presetN <= 1'b1;
        put(3'h3, 8'h77);
        chk("after preset", bus4, e4);
    endtask
    task automatic t_shut();
        shutN <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk("quad open", open4, 48'h0f);
        chk("six open", open6, 48'h0);
        chk("kept latches", bus4, e4);
        shutN <= 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("quad closed", open4, 48'h0);
        chk("restored", bus4, e4);
    endtask
    task automatic t_drain();
        chk("drive level", out4, 48'h0);
        chk("pin low", sdoPin, 48'h0);
        chk("six enable", oe6, 48'h0);
        put(3'h7, 8'h00);
        chk("pin high", sdoPin, 48'h1);
        chk("refused quad", bus4, e4);
        chk("refused six", bus6, e6);
    endtask
    // reset in mid-run brings every latch back to midscale
    task automatic t_reset();
        put(3'h2, 8'h3c);
        rst_n <= 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n <= 1'b1;
        e4 = {6{MIDSCALE}};
        e6 = {6{MIDSCALE}};
        repeat (4) @(negedge sys_clk);
        chk("reset quad", bus4, e4);
        chk("reset six", bus6, e6);
        put(3'h1, 8'h2d);
        chk("write after reset", bus6, e6);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #300000;
        mismatches++;
        test_done();
    end
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("power-up", bus4, e4);
        t_codes();
        t_preset();
        t_shut();
        t_drain();
        t_reset();
        test_done();
    end
endmodule
